/* hw/vab_params.svh */
// Register offsets, field positions, reset values and constants of the video adjust register bank
`ifndef VAB_PARAMS_SVH
`define VAB_PARAMS_SVH

// ****************************************
// Register subaddresses
// ****************************************
// Six bits wide: the upper three registers sit above the five-bit subaddress field
`define VAB_OFS_SIG_MID 6'h1a
`define VAB_OFS_SIG_LOW 6'h1b
`define VAB_OFS_LUMA_GAIN 6'h1d
`define VAB_OFS_U_GAIN 6'h1e
`define VAB_OFS_V_GAIN 6'h1f
`define VAB_OFS_PHASE 6'h20
`define VAB_OFS_PEDESTAL 6'h21
`define VAB_OFS_PEAKING 6'h22

// ****************************************
// Field positions and widths
// ****************************************
`define VAB_GAIN_MSB 5
`define VAB_PED_MSB 4
`define VAB_PEAK_MSB 3
`define VAB_SHARED_MID_MSB 5
`define VAB_COPY_ONLY_LSB 6

// ****************************************
// Reset values and code limits
// ****************************************
`define VAB_RST_SIG 8'h00
`define VAB_RST_GAIN 8'h20
`define VAB_RST_PHASE 8'h80
`define VAB_RST_PEDESTAL 8'h00
`define VAB_RST_PEAKING 8'h06
`define VAB_PED_MAX 5'h12
`define VAB_PEAK_MAX 4'hc
`define VAB_PHASE_ZERO 8'h80
// Gain factor is 0.75 + code/128, i.e. (96 + code)/128
`define VAB_GAIN_BASE 8'h60

`endif

/* hw/vab_pkg.sv */
// Types shared by the video adjust register bank
package vab_pkg;

    typedef enum logic [1:0] {
        VAB_ST_IDLE = 2'b00,
        VAB_ST_ADDR = 2'b01,
        VAB_ST_DATA = 2'b11
    } vab_state_t;

    // One host register access from the serial subaddress interface
    typedef struct packed {
        logic wr;
        logic [5:0] addr;
        logic [7:0] data;
    } vab_req_t;

    // Settings presented to the video paths
    typedef struct packed {
        // Eight bits: 96 + 63 reaches 159, past a seven-bit range
        logic [7:0] luma_mult;
        logic [7:0] u_mult;
        logic [7:0] v_mult;
        logic signed [8:0] phase_steps;
        logic [4:0] pedestal_code;
        logic [3:0] peaking_code;
        logic pedestal_ok;
        logic peaking_ok;
    } vab_adj_t;

    // Payload for the vertical blanking line insertion
    typedef struct packed {
        logic [19:0] copy_payload;
        logic [13:0] wide_payload;
        logic is_pal;
    } vab_line_t;

endpackage

/* hw/vab_line_map.sv */
// Maps the shared signalling registers onto copy-management or wide-screen payloads
`timescale 1ns/1ns
`include "vab_params.svh"
module vab_line_map
    import vab_pkg::*;
(
    input wire logic [7:0] i_sig_first,
    input wire logic [7:0] i_sig_mid,
    input wire logic [7:0] i_sig_low,
    input wire logic i_pal_mode,
    output vab_line_t o_line
);

    // ****************************************
    // Payload assembly
    // ****************************************
    // Both payloads are always formed; the standard only selects which the inserter uses
    always_comb begin
        o_line.is_pal = i_pal_mode;
        o_line.copy_payload[7:0] = i_sig_low;
        o_line.copy_payload[15:8] = i_sig_mid;
        o_line.copy_payload[19:16] = i_sig_first[3:0];
        o_line.wide_payload[7:0] = i_sig_low;
        // Upper two bits of the mid register never reach the wide-screen word
        o_line.wide_payload[13:8] = i_sig_mid[`VAB_SHARED_MID_MSB:0];
    end

endmodule

/* hw/vab_top.sv */
// Video adjust register bank: host registers for line signalling and picture adjustment
//
// Summary of operation
// - Shared bits follow NTSC copy or PAL wide-screen
// - Mid register top bits are copy data only
// - Low register eight bits form shared field
// - Luma gain is 0.75 plus code over 128
// - U gain is 0.75 plus code over 128
// - V gain is 0.75 plus code over 128
// - Hue offset is (code minus 128) steps
// - Code 80 hex gives zero hue shift
// - Hue shifts active video, burst stays unshifted
// - Pedestal code 0 to 18 gives 0-7.5 IRE
// - Pedestal applies in PAL and NTSC
// - Thirteen peaking responses, codes 0 to 12 of four-bit code
// - Copy payload C8-C15 mid, C0-C7 low
// - Wide payload W0-W7 low, W8-W13 mid
`timescale 1ns/1ns
`include "vab_params.svh"
module vab_top
    import vab_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [4:0] i_register_subaddress,
    input wire logic [5:0] i_subaddress_hi,
    input wire logic [7:0] i_wr_data,
    input wire logic [7:0] i_sig_first,
    input wire logic i_pal_mode,
    input wire logic i_burst_gate,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_addr_hit,
    output vab_adj_t o_adj,
    output vab_line_t o_line,
    output logic signed [8:0] o_active_phase_steps
);

    // ****************************************
    // Address decode
    // ****************************************
    // Bus address is six bits: subaddresses 0x20-0x22 need the bit above the five-bit field
    logic [5:0] addr;
    // Register indices into the select vector, in read-back order
    localparam int IX_SIG_MID = 0;
    localparam int IX_SIG_LOW = 1;
    localparam int IX_LUMA_GAIN = 2;
    localparam int IX_U_GAIN = 3;
    localparam int IX_V_GAIN = 4;
    localparam int IX_PHASE = 5;
    localparam int IX_PEDESTAL = 6;
    localparam int IX_PEAKING = 7;
    localparam int NREG = 8;
    logic [NREG-1:0] reg_sel;
    logic [7:0] bank_view [NREG];
    logic [7:0] sig_mid_ff;
    logic [7:0] sig_low_ff;
    logic [7:0] luma_gain_ff;
    logic [7:0] u_gain_ff;
    logic [7:0] v_gain_ff;
    logic [7:0] phase_ff;
    logic [7:0] pedestal_ff;
    logic [7:0] peaking_ff;
    logic [7:0] nxt_rd_data;
    logic [7:0] rd_data_ff;
    logic rd_valid_ff;
    vab_adj_t adj_ff;
    logic signed [8:0] active_phase_ff;

    assign addr = {i_subaddress_hi[0], i_register_subaddress};

    // Six-bit offset of each bank register; offsets above 0x1f carry their top bit in i_subaddress_hi
    function automatic logic [5:0] vab_ofs(input int idx);
        case (idx)
            IX_SIG_MID: vab_ofs = `VAB_OFS_SIG_MID;
            IX_SIG_LOW: vab_ofs = `VAB_OFS_SIG_LOW;
            IX_LUMA_GAIN: vab_ofs = `VAB_OFS_LUMA_GAIN;
            IX_U_GAIN: vab_ofs = `VAB_OFS_U_GAIN;
            IX_V_GAIN: vab_ofs = `VAB_OFS_V_GAIN;
            IX_PHASE: vab_ofs = `VAB_OFS_PHASE;
            IX_PEDESTAL: vab_ofs = `VAB_OFS_PEDESTAL;
            default: vab_ofs = `VAB_OFS_PEAKING;
        endcase
    endfunction

    // One select line per register, shared by the write, read-back and hit logic
    for (genvar g = 0; g < NREG; g++) begin : g_sel
        assign reg_sel[g] = (addr == vab_ofs(g));
    end

    // Offsets are distinct, so at most one select is high
    logic hit;
    assign hit = |reg_sel;
    assign o_addr_hit = hit;

    // ****************************************
    // Signalling registers
    // ****************************************
    // Stored as written; copy or wide-screen meaning is given later by the standard
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sig_mid_ff <= `VAB_RST_SIG;
            sig_low_ff <= `VAB_RST_SIG;
        end else if (i_wr_en) begin
            if (reg_sel[IX_SIG_MID]) begin
                sig_mid_ff <= i_wr_data;
            end
            if (reg_sel[IX_SIG_LOW]) begin
                sig_low_ff <= i_wr_data;
            end
        end
    end

    // ****************************************
    // Gain registers
    // ****************************************
    // Reserved bits are stored as written so read-back matches; the video path ignores them
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            luma_gain_ff <= `VAB_RST_GAIN;
            u_gain_ff <= `VAB_RST_GAIN;
            v_gain_ff <= `VAB_RST_GAIN;
        end else if (i_wr_en) begin
            if (reg_sel[IX_LUMA_GAIN]) begin
                luma_gain_ff <= i_wr_data;
            end
            if (reg_sel[IX_U_GAIN]) begin
                u_gain_ff <= i_wr_data;
            end
            if (reg_sel[IX_V_GAIN]) begin
                v_gain_ff <= i_wr_data;
            end
        end
    end

    // ****************************************
    // Hue, pedestal and peaking registers
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_ff <= `VAB_RST_PHASE;
            pedestal_ff <= `VAB_RST_PEDESTAL;
            peaking_ff <= `VAB_RST_PEAKING;
        end else if (i_wr_en) begin
            if (reg_sel[IX_PHASE]) begin
                phase_ff <= i_wr_data;
            end
            if (reg_sel[IX_PEDESTAL]) begin
                pedestal_ff <= i_wr_data;
            end
            if (reg_sel[IX_PEAKING]) begin
                peaking_ff <= i_wr_data;
            end
        end
    end

    // ****************************************
    // Read-back
    // ****************************************
    // Registers in select order, so decode and read-back share one index
    assign bank_view[IX_SIG_MID] = sig_mid_ff;
    assign bank_view[IX_SIG_LOW] = sig_low_ff;
    assign bank_view[IX_LUMA_GAIN] = luma_gain_ff;
    assign bank_view[IX_U_GAIN] = u_gain_ff;
    assign bank_view[IX_V_GAIN] = v_gain_ff;
    assign bank_view[IX_PHASE] = phase_ff;
    assign bank_view[IX_PEDESTAL] = pedestal_ff;
    assign bank_view[IX_PEAKING] = peaking_ff;

    // Unmapped addresses read as zero; selects are one-hot, so OR-ing masked bytes is enough
    always_comb begin
        nxt_rd_data = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            nxt_rd_data = nxt_rd_data | ({8{reg_sel[i]}} & bank_view[i]);
        end
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_data_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= i_rd_en;
            if (i_rd_en) begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

    assign o_rd_data = rd_data_ff;
    assign o_rd_valid = rd_valid_ff;

    // ****************************************
    // Video path settings
    // ****************************************
    // Registered so a host write takes effect one cycle later, on whole settings at once
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            adj_ff <= '0;
        end else begin
            // Multiplier over 128: 96 + code spans 0.75 to 1.242
            adj_ff.luma_mult <= `VAB_GAIN_BASE + {2'b00, luma_gain_ff[`VAB_GAIN_MSB:0]};
            adj_ff.u_mult <= `VAB_GAIN_BASE + {2'b00, u_gain_ff[`VAB_GAIN_MSB:0]};
            adj_ff.v_mult <= `VAB_GAIN_BASE + {2'b00, v_gain_ff[`VAB_GAIN_MSB:0]};
            // Signed steps of 0.17578125 degrees; 0x80 gives zero
            adj_ff.phase_steps <= $signed({1'b0, phase_ff}) - $signed({1'b0, `VAB_PHASE_ZERO});
            // Same pedestal in both standards, no mode term on purpose
            adj_ff.pedestal_code <= pedestal_ff[`VAB_PED_MSB:0];
            adj_ff.pedestal_ok <= (pedestal_ff[`VAB_PED_MSB:0] <= `VAB_PED_MAX);
            adj_ff.peaking_code <= peaking_ff[`VAB_PEAK_MSB:0];
            adj_ff.peaking_ok <= (peaking_ff[`VAB_PEAK_MSB:0] <= `VAB_PEAK_MAX);
        end
    end

    assign o_adj = adj_ff;

    // ****************************************
    // Hue gating against burst
    // ****************************************
    // Burst keeps the reference phase, so the offset is forced to zero while it is gated
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            active_phase_ff <= '0;
        end else if (i_burst_gate) begin
            active_phase_ff <= '0;
        end else begin
            active_phase_ff <= adj_ff.phase_steps;
        end
    end

    assign o_active_phase_steps = active_phase_ff;

    // ****************************************
    // Line insertion payload
    // ****************************************
    vab_line_map u_line_map (
        .i_sig_first(i_sig_first),
        .i_sig_mid(sig_mid_ff),
        .i_sig_low(sig_low_ff),
        .i_pal_mode(i_pal_mode),
        .o_line(o_line)
    );

endmodule

/* dv/vab_properties.sv */
// Port-level checker of the video adjust register bank
`timescale 1ns/1ns
module vab_properties
    import vab_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [4:0] i_register_subaddress,
    input wire logic [5:0] i_subaddress_hi,
    input wire logic [7:0] i_wr_data,
    input wire logic [7:0] i_sig_first,
    input wire logic i_pal_mode,
    input wire logic i_burst_gate,
    input wire logic [7:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic o_addr_hit,
    input wire vab_adj_t o_adj,
    input wire vab_line_t o_line,
    input wire logic signed [8:0] o_active_phase_steps
);
    // ********
    // Assertions
    // ********
    // Full address as the bank decodes it
    logic [5:0] wa;
    assign wa = {i_subaddress_hi[0], i_register_subaddress};
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    rd_pulse_a: assert property (i_rd_en |=> o_rd_valid)
        else $error("read strobe gave no valid pulse");
    rd_cause_a: assert property (o_rd_valid |-> $past(i_rd_en))
        else $error("valid pulse without read strobe");
    unmapped_zero_a: assert property (i_rd_en && !o_addr_hit |=> o_rd_data == 8'h00)
        else $error("unmapped read returned data");
    // A second write to the same place in the next cycle reaches o_adj only after the check
    luma_gain_a: assert property (i_wr_en && wa == 6'h1d ##1 !(i_wr_en && wa == 6'h1d)
        |=> o_adj.luma_mult == 8'h60 + $past(i_wr_data[5:0], 2))
        else $error("luma multiplier not base plus code");
    burst_zero_a: assert property (i_burst_gate |=> o_active_phase_steps == 9'sh000)
        else $error("hue shift applied during burst");
    hue_follow_a: assert property (!i_burst_gate |=> o_active_phase_steps == $past(o_adj.phase_steps))
        else $error("active phase does not follow hue setting");
    copy_first_a: assert property (o_line.copy_payload[19:16] == i_sig_first[3:0])
        else $error("copy payload top bits wrong");
    wide_share_a: assert property (o_line.wide_payload == o_line.copy_payload[13:0])
        else $error("wide payload does not share copy bits");
    mode_follow_a: assert property (o_line.is_pal == i_pal_mode)
        else $error("payload mode does not follow standard");
    // Settings hold all zero through reset and first follow the registers one edge after release
    ped_range_a: assert property ($past(i_arst_n) |-> o_adj.pedestal_ok == (o_adj.pedestal_code <= 5'h12))
        else $error("pedestal range flag wrong");
    peak_range_a: assert property ($past(i_arst_n) |-> o_adj.peaking_ok == (o_adj.peaking_code <= 4'hc))
        else $error("peaking range flag wrong");
    // Main scenarios reached
    cover property (i_wr_en && wa == 6'h20);
    cover property (i_rd_en && !o_addr_hit);
    cover property (i_pal_mode && i_burst_gate);
endmodule

bind vab_top vab_properties u_props (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .i_register_subaddress(i_register_subaddress), .i_subaddress_hi(i_subaddress_hi),
    .i_wr_data(i_wr_data), .i_sig_first(i_sig_first), .i_pal_mode(i_pal_mode), .i_burst_gate(i_burst_gate),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_addr_hit(o_addr_hit), .o_adj(o_adj),
    .o_line(o_line), .o_active_phase_steps(o_active_phase_steps));

/* dv/tb_top.sv */
// Self-checking bench of the video adjust register bank
`timescale 1ns/1ns
`include "vab_params.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top
    import vab_pkg::*;
;
    logic mclk, arst_n, wr_en, rd_en, pal, burst, rval, hit;
    logic [4:0] sub;
    logic [5:0] hi;
    logic [7:0] wdat, first, rdat;
    vab_adj_t adj;
    vab_line_t line;
    logic signed [8:0] aph;
    int errors, cmp_count, cyc;
    logic [5:0] addrs [8] = '{6'h1a, 6'h1b, 6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22};
    logic [7:0] rsts [8] = '{`VAB_RST_SIG, `VAB_RST_SIG, `VAB_RST_GAIN, `VAB_RST_GAIN, `VAB_RST_GAIN,
        `VAB_RST_PHASE, `VAB_RST_PEDESTAL, `VAB_RST_PEAKING};

    vab_top uut (.i_mclk(mclk), .i_arst_n(arst_n), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_register_subaddress(sub), .i_subaddress_hi(hi), .i_wr_data(wdat), .i_sig_first(first),
        .i_pal_mode(pal), .i_burst_gate(burst), .o_rd_data(rdat), .o_rd_valid(rval), .o_addr_hit(hit),
        .o_adj(adj), .o_line(line), .o_active_phase_steps(aph));

    // ********
    // Bus tasks
    // ********
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        {hi, sub} <= {5'h00, a};
        wdat <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    // Read data is taken in the cycle the valid pulse stands
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge mclk);
        rd_en <= 1'b1;
        {hi, sub} <= {5'h00, a};
        @(posedge mclk);
        rd_en <= 1'b0;
        @(negedge mclk);
        `CHK("rd_valid", 1'b1, rval)
        d = rdat;
    endtask

    // Settings reach the video side two edges after a write
    task automatic settle;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_reset;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            rd(addrs[i], v);
            `CHK("reset value", rsts[i], v)
            `CHK("addr_hit", 1'b1, hit)
        end
        `CHK("luma_mult", `VAB_GAIN_BASE + 8'h20, adj.luma_mult)
        `CHK("peaking", 4'h6, adj.peaking_code)
    endtask

    task automatic t_gain;
        logic [5:0] codes [3] = '{6'h00, 6'h3f, 6'h13};
        logic [7:0] v;
        logic [7:0] g;
        for (int i = 0; i < 3; i++) begin
            for (int k = 0; k < 3; k++) begin
                wr(addrs[2 + i], {2'b00, codes[k]});
                settle();
                g = (i == 0) ? adj.luma_mult : (i == 1) ? adj.u_mult : adj.v_mult;
                `CHK("gain mult", `VAB_GAIN_BASE + {2'b00, codes[k]}, g)
                rd(addrs[2 + i], v);
                `CHK("gain readback", {2'b00, codes[k]}, v)
            end
        end
    endtask

    task automatic t_hue;
        logic [7:0] codes [4] = '{8'h00, 8'h80, 8'hff, 8'h90};
        logic signed [8:0] e;
        for (int k = 0; k < 4; k++) begin
            wr(6'h20, codes[k]);
            settle();
            e = {1'b0, codes[k]} - 9'h080;
            `CHK("phase_steps", e, adj.phase_steps)
            `CHK("active phase", e, aph)
            @(posedge mclk);
            burst <= 1'b1;
            pal <= k[0];
            @(posedge mclk);
            burst <= 1'b0;
            @(negedge mclk);
            `CHK("burst phase", 9'sh000, aph)
        end
    endtask

    // Pedestal and peaking codes at and just past their top values; the codes past the top
    // are written on purpose to see them flagged, ordinary host software avoids them
    task automatic t_range;
        logic [7:0] d [4] = '{8'h12, 8'h13, 8'h0c, 8'h0d};
        for (int k = 0; k < 4; k++) begin
            wr(k < 2 ? 6'h21 : 6'h22, d[k]);
            settle();
            `CHK("range ok", k[0] == 1'b0, k < 2 ? adj.pedestal_ok : adj.peaking_ok)
            `CHK("level code", d[k][4:0], k < 2 ? adj.pedestal_code : {1'b0, adj.peaking_code})
            @(posedge mclk);
            pal <= k[0];
            @(negedge mclk);
            `CHK("pedestal kept", (k == 0) ? 5'h12 : 5'h13, adj.pedestal_code)
        end
    endtask

    task automatic t_line;
        logic [7:0] v;
        @(posedge mclk);
        first <= 8'h09;
        wr(6'h1a, 8'hc5);
        wr(6'h1b, 8'h3a);
        settle();
        for (int p = 0; p < 2; p++) begin
            @(posedge mclk);
            pal <= p[0];
            @(negedge mclk);
            `CHK("copy", 20'h9c53a, line.copy_payload)
            `CHK("wide", 14'h053a, line.wide_payload)
            `CHK("is_pal", p[0], line.is_pal)
        end
        wr(6'h1c, 8'h5a);
        rd(6'h1c, v);
        `CHK("unmapped", 8'h00, v)
        `CHK("addr_hit", 1'b0, hit)
    endtask

    task automatic close_out;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Hang guard, well above the roughly 160 cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            close_out();
        end
    end

    initial begin
        {arst_n, wr_en, rd_en, pal, burst, sub, hi, wdat, first} = '0;
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset();
        t_gain();
        t_hue();
        t_range();
        t_line();
        close_out();
    end
endmodule
